// >>> include/tmp_defs.svh
// timer control block: register offsets, field positions, reset values
// assumes inclusion by bare name from the design files
`ifndef TMP_DEFS_SVH
`define TMP_DEFS_SVH

// register offsets on the 3-bit byte port
`define TMP_ADDR_CNT_HI 3'h0
`define TMP_ADDR_CNT_LO 3'h1
`define TMP_ADDR_RLD_HI 3'h2
`define TMP_ADDR_RLD_LO 3'h3
`define TMP_ADDR_PWM_HI 3'h4
`define TMP_ADDR_PWM_LO 3'h5
`define TMP_ADDR_CTL0 3'h6
`define TMP_ADDR_CTL1 3'h7

// timer_control_zero fields
`define TMP_C0_MODE_TOP 7
`define TMP_C0_TICFG_HI 6
`define TMP_C0_TICFG_LO 5
`define TMP_C0_DBAND_HI 3
`define TMP_C0_DBAND_LO 1
`define TMP_C0_INPCAP 0
`define TMP_C0_WMASK 8'hEE

// timer_control_one fields
`define TMP_C1_TEN 7
`define TMP_C1_POL 6
`define TMP_C1_PRESCALE_SELECT_HI 5
`define TMP_C1_PRESCALE_SELECT_LO 3
`define TMP_C1_MODE_HI 2
`define TMP_C1_MODE_LO 0

// reset values and the reload landing point
`define TMP_RST_CNT 16'h0001
`define TMP_RST_RLD 16'hFFFF
`define TMP_RST_RLD_HOLD 8'hFF
`define TMP_RST_PWM 16'h0000
`define TMP_RST_CTL 8'h00
`define TMP_RELOAD_VAL 16'h0001

`endif

// >>> include/tmp_pkg.sv
// timer control block: shared types
// assumes nothing beyond a SystemVerilog compiler
package tmp_pkg;

  // operating mode codes, top bit from timer_control_zero
  typedef enum logic [3:0] {
    TMP_ONE_SHOT = 4'h0,
    TMP_CONTINUOUS = 4'h1,
    TMP_COUNTER = 4'h2,
    TMP_PWM_SINGLE = 4'h3,
    TMP_CAPTURE = 4'h4,
    TMP_COMPARE = 4'h5,
    TMP_GATED = 4'h6,
    TMP_CAP_CMP = 4'h7,
    TMP_PWM_DUAL = 4'h8,
    TMP_CAP_RESTART = 4'h9,
    TMP_CMP_COUNTER = 4'hA
  } tmp_mode_e;

  // run control, one-hot
  typedef enum logic [2:0] {
    TMP_ST_OFF = 3'b001,
    TMP_ST_ARM = 3'b010,
    TMP_ST_RUN = 3'b100
  } tmp_state_e;

endpackage : tmp_pkg

// >>> include/tmp_dband_if.sv
// timer control block: carrier between control logic and dead-band delay
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface tmp_dband_if;
  logic [1:0] raw;
  logic act_lvl;
  logic [2:0] dly_code;
  logic bypass;
  logic [1:0] dout;

  modport ctrl (output raw, output act_lvl, output dly_code, output bypass, input dout);
  modport dband (input raw, input act_lvl, input dly_code, input bypass, output dout);
endinterface : tmp_dband_if

// >>> core/tmp_deadband.sv
// timer control block: dead-band delay for output and complement
// assumes raw levels come from flip-flops on i_clk
`timescale 1ns/100ps
module tmp_deadband #(
  parameter int DLY_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  tmp_dband_if.dband db
);

  ////////////////////////////////////////////////////////////////////////////
  // delay length: code 0 none, otherwise two to the code
  logic [DLY_W-1:0] dly;
  assign dly = (db.dly_code == 3'h0) ? '0 : DLY_W'(9'h001 << db.dly_code);

  ////////////////////////////////////////////////////////////////////////////
  // one delay stage per output; only moves to the active level wait
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ch
      localparam logic RST_LVL = (gi == 0) ? 1'b0 : 1'b1;
      logic [DLY_W-1:0] cnt_r;
      logic out_r;
      always_ff @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          cnt_r <= '0;
          out_r <= RST_LVL;
        end
        else if (db.bypass || (db.raw[gi] != db.act_lvl))
        begin
          cnt_r <= '0; // inactive moves pass at once
          out_r <= db.raw[gi];
        end
        else if (cnt_r >= dly)
          out_r <= db.act_lvl;
        else
          cnt_r <= cnt_r + 1'b1;
      end
      assign db.dout[gi] = out_r;
    end
  endgenerate

endmodule : tmp_deadband

// >>> core/tmp_timer.sv
// timer control block: mode decode, polarity, prescaler, capture, dead band
// assumes a byte register port on i_clk and an asynchronous timer input pin
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`include "tmp_defs.svh"

module tmp_timer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_timer_in,
  output logic o_timer_out_pin,
  output logic o_timer_out_comp,
  output logic o_timer_evt
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] rld_r;
  logic [7:0] rld_hold_r;
  logic [15:0] pwm_r;
  logic [7:0] ctl0_r;
  logic [7:0] ctl0_nxt;
  logic [7:0] ctl1_r;
  logic [7:0] ctl1_nxt;
  logic [6:0] pre_r;
  logic out_raw_r;
  logic out_raw_nxt;
  logic evt_r;
  logic [7:0] rdata_r;
  logic pin_r;
  logic comp_r;
  logic in_s1_r;
  logic in_s2_r;
  logic in_d_r;
  tmp_pkg::tmp_state_e st_r;
  tmp_pkg::tmp_state_e st_nxt;

  tmp_dband_if dbif ();

  ////////////////////////////////////////////////////////////////////////////
  // control field decode
  wire ten = ctl1_r[`TMP_C1_TEN];
  wire pol = ctl1_r[`TMP_C1_POL];
  wire [2:0] prescale_select = ctl1_r[`TMP_C1_PRESCALE_SELECT_HI:`TMP_C1_PRESCALE_SELECT_LO];
  wire [1:0] ticfg = ctl0_r[`TMP_C0_TICFG_HI:`TMP_C0_TICFG_LO];
  wire [2:0] dband = ctl0_r[`TMP_C0_DBAND_HI:`TMP_C0_DBAND_LO];
  wire [3:0] mode_code = {ctl0_r[`TMP_C0_MODE_TOP], ctl1_r[`TMP_C1_MODE_HI:`TMP_C1_MODE_LO]};
  tmp_pkg::tmp_mode_e mode;
  assign mode = tmp_pkg::tmp_mode_e'(mode_code);

  // mode classes; reserved codes fall in none of them and stay idle
  wire m_toggle = (mode == tmp_pkg::TMP_ONE_SHOT) || (mode == tmp_pkg::TMP_CONTINUOUS) ||
                  (mode == tmp_pkg::TMP_COUNTER) || (mode == tmp_pkg::TMP_COMPARE) ||
                  (mode == tmp_pkg::TMP_CMP_COUNTER);
  wire m_pwm1 = (mode == tmp_pkg::TMP_PWM_SINGLE);
  wire m_pwm2 = (mode == tmp_pkg::TMP_PWM_DUAL);
  wire m_pwm = m_pwm1 || m_pwm2;
  wire m_cap = (mode == tmp_pkg::TMP_CAPTURE) || (mode == tmp_pkg::TMP_CAP_RESTART);
  wire m_capcmp = (mode == tmp_pkg::TMP_CAP_CMP);
  wire m_gated = (mode == tmp_pkg::TMP_GATED);
  wire m_edge_cnt = (mode == tmp_pkg::TMP_COUNTER) || (mode == tmp_pkg::TMP_CMP_COUNTER);

  ////////////////////////////////////////////////////////////////////////////
  // timer input: two-stage synchroniser, then a history flop for edges
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      in_s1_r <= 1'b0;
      in_s2_r <= 1'b0;
      in_d_r <= 1'b0;
    end
    else
    begin
      in_s1_r <= i_timer_in;
      in_s2_r <= in_s1_r;
      in_d_r <= in_s2_r;
    end
  end

  // polarity picks which edge counts as the selected one
  wire in_rise = in_s2_r && !in_d_r;
  wire in_fall = !in_s2_r && in_d_r;
  wire sel_edge = pol ? in_fall : in_rise;
  wire deassert_edge = pol ? in_rise : in_fall;
  wire in_active = in_s2_r ^ pol;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: tick when the low code bits of the divider are all ones
  wire [7:0] pre_one = 8'h01 << prescale_select;
  wire [6:0] pre_mask = pre_one[6:0] - 7'h01; // code 7 wraps to all ones
  wire tick = ten && ((pre_r & pre_mask) == pre_mask);

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      pre_r <= 7'h00;
    else if (!ten)
      pre_r <= 7'h00;
    else
      pre_r <= pre_r + 7'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // run control: capture/compare waits for its first edge before counting
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      tmp_pkg::TMP_ST_OFF:
        if (ten)
          st_nxt = m_capcmp ? tmp_pkg::TMP_ST_ARM : tmp_pkg::TMP_ST_RUN;
      tmp_pkg::TMP_ST_ARM:
        if (!ten)
          st_nxt = tmp_pkg::TMP_ST_OFF;
        else if (sel_edge)
          st_nxt = tmp_pkg::TMP_ST_RUN;
      tmp_pkg::TMP_ST_RUN:
        if (!ten)
          st_nxt = tmp_pkg::TMP_ST_OFF;
      default:
        st_nxt = tmp_pkg::TMP_ST_OFF;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      st_r <= tmp_pkg::TMP_ST_OFF;
    else
      st_r <= st_nxt;
  end

  wire running = ten && (st_r == tmp_pkg::TMP_ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // counting step and timer events
  wire step_tick = m_toggle && !m_edge_cnt || m_pwm || m_cap || m_capcmp;
  wire cnt_step = running && ((step_tick && tick) || (m_edge_cnt && sel_edge) ||
                              (m_gated && tick && in_active));
  wire reload_hit = cnt_step && (cnt_r == rld_r);
  wire pwm_hit = cnt_step && m_pwm && (cnt_r == pwm_r);
  wire cap_evt = running && sel_edge && (m_cap || m_capcmp);
  wire gate_evt = running && m_gated && deassert_edge;
  wire inp_evt = cap_evt || gate_evt;
  wire rc_evt = reload_hit || pwm_hit;
  // interrupt configuration filters which events leave the block
  wire evt_any = !ticfg[1] ? (inp_evt || rc_evt) : (ticfg[0] ? rc_evt : inp_evt);
  wire oneshot_done = reload_hit && (mode == tmp_pkg::TMP_ONE_SHOT);
  wire restart = cap_evt && (mode == tmp_pkg::TMP_CAP_RESTART);

  ////////////////////////////////////////////////////////////////////////////
  // register port decode
  wire wr_cnt_hi = i_wr && (i_addr == `TMP_ADDR_CNT_HI);
  wire wr_cnt_lo = i_wr && (i_addr == `TMP_ADDR_CNT_LO);
  wire wr_rld_hi = i_wr && (i_addr == `TMP_ADDR_RLD_HI);
  wire wr_rld_lo = i_wr && (i_addr == `TMP_ADDR_RLD_LO);
  wire wr_pwm_hi = i_wr && (i_addr == `TMP_ADDR_PWM_HI);
  wire wr_pwm_lo = i_wr && (i_addr == `TMP_ADDR_PWM_LO);
  wire wr_ctl0 = i_wr && (i_addr == `TMP_ADDR_CTL0);
  wire wr_ctl1 = i_wr && (i_addr == `TMP_ADDR_CTL1);

  // counter: a software write lands on the next edge and wins over counting
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (reload_hit || restart)
      cnt_nxt = `TMP_RELOAD_VAL;
    else if (cnt_step)
      cnt_nxt = cnt_r + 16'h0001;
    if (wr_cnt_hi)
      cnt_nxt[15:8] = i_wdata;
    if (wr_cnt_lo)
      cnt_nxt[7:0] = i_wdata;
  end

  // control: one-shot drops its own enable; input-capture flag set wins
  always_comb
  begin
    ctl0_nxt = ctl0_r;
    ctl1_nxt = ctl1_r;
    if (oneshot_done)
      ctl1_nxt[`TMP_C1_TEN] = 1'b0;
    if (wr_ctl1)
      ctl1_nxt = i_wdata;
    if (wr_ctl0)
      ctl0_nxt = i_wdata & `TMP_C0_WMASK;
    if (evt_any)
      ctl0_nxt[`TMP_C0_INPCAP] = inp_evt;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r <= `TMP_RST_CNT;
      ctl0_r <= `TMP_RST_CTL;
      ctl1_r <= `TMP_RST_CTL;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      ctl0_r <= ctl0_nxt;
      ctl1_r <= ctl1_nxt;
    end
  end

  // reload pair updates as one word through the holding byte
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rld_r <= `TMP_RST_RLD;
      rld_hold_r <= `TMP_RST_RLD_HOLD;
    end
    else
    begin
      if (wr_rld_hi)
        rld_hold_r <= i_wdata;
      if (wr_rld_lo)
        rld_r <= {rld_hold_r, i_wdata};
    end
  end

  // pulse-width pair; a capture overrides a same-cycle write
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      pwm_r <= `TMP_RST_PWM;
    else if (cap_evt)
      pwm_r <= cnt_r;
    else
    begin
      if (wr_pwm_hi)
        pwm_r[15:8] <= i_wdata;
      if (wr_pwm_lo)
        pwm_r[7:0] <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, data one cycle after the strobe
  logic [7:0] rd_mux;
  always_comb
  begin
    case (i_addr)
      `TMP_ADDR_CNT_HI: rd_mux = cnt_r[15:8];
      `TMP_ADDR_CNT_LO: rd_mux = cnt_r[7:0];
      `TMP_ADDR_RLD_HI: rd_mux = rld_r[15:8];
      `TMP_ADDR_RLD_LO: rd_mux = rld_r[7:0];
      `TMP_ADDR_PWM_HI: rd_mux = pwm_r[15:8];
      `TMP_ADDR_PWM_LO: rd_mux = pwm_r[7:0];
      `TMP_ADDR_CTL0: rd_mux = ctl0_r;
      `TMP_ADDR_CTL1: rd_mux = ctl1_r;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rdata_r <= 8'h00;
    else if (i_rd)
      rdata_r <= rd_mux;
    else
      rdata_r <= 8'h00; // data stands only in the cycle after the strobe
  end

  ////////////////////////////////////////////////////////////////////////////
  // raw timer output; enabled updates act only on events, so a polarity
  // change while running waits for the next match or reload
  always_comb
  begin
    out_raw_nxt = out_raw_r;
    if (!ten)
      out_raw_nxt = pol;
    else if (m_toggle && reload_hit)
      out_raw_nxt = !out_raw_r;
    else if (m_pwm && reload_hit)
      out_raw_nxt = pol;
    else if (m_pwm && pwm_hit)
      out_raw_nxt = !pol;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      out_raw_r <= 1'b0;
      evt_r <= 1'b0;
    end
    else
    begin
      out_raw_r <= out_raw_nxt;
      evt_r <= evt_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dead band applies only in dual mode while enabled; complement is the
  // inverse of the raw output so both share one decision
  assign dbif.raw = {!out_raw_r, out_raw_r};
  assign dbif.act_lvl = !pol;
  assign dbif.dly_code = dband;
  assign dbif.bypass = !(m_pwm2 && ten);

  tmp_deadband #(
    .DLY_W(8)
  ) u_dband (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .db(dbif.dband)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin registers; costs one cycle but keeps pins glitch free
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_r <= 1'b0;
      comp_r <= 1'b1;
    end
    else
    begin
      pin_r <= dbif.dout[0];
      comp_r <= dbif.dout[1];
    end
  end

  assign o_timer_out_pin = pin_r;
  assign o_timer_out_comp = comp_r;
  assign o_timer_evt = evt_r;
  assign o_rdata = rdata_r;

endmodule : tmp_timer

// >>> sim/tmp_pin_model.sv
// timer input pin driver standing outside the device
// assumes the bench sets the wanted level off the sampling edge
`timescale 1ns/100ps
module tmp_pin_model (
  input wire logic i_clk,
  input wire logic i_lvl,
  output logic o_pin
);
  // the far side only moves the pin at clock edges, so no pulse is narrower than a cycle
  always_ff @(posedge i_clk)
    o_pin <= i_lvl;
endmodule : tmp_pin_model

// >>> sim/tmp_timer_monitor.sv
// concurrent checks on the timer control block ports
// assumes one clock, asynchronous active-high reset
`timescale 1ns/100ps
module tmp_timer_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_timer_in,
  input wire logic o_timer_out_pin,
  input wire logic o_timer_out_comp,
  input wire logic o_timer_evt
);
  logic [7:0] c0_r;
  logic [7:0] c1_r;
  logic [2:0] quiet_r;
  wire en = c1_r[7];
  wire pol = c1_r[6];
  wire [3:0] mode = {c0_r[7], c1_r[2:0]};
  wire ctl_wr = i_wr && (i_addr[2:1] == 2'b11);
  // shadow of the control bytes; one-shot self clear is not modelled, so it is never enabled
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
    begin
      c0_r <= 8'h00;
      c1_r <= 8'h00;
      quiet_r <= 3'h0;
    end
    else
    begin
      if (ctl_wr && !i_addr[0]) c0_r <= i_wdata;
      if (ctl_wr && i_addr[0]) c1_r <= i_wdata;
      quiet_r <= (ctl_wr || en) ? 3'h0 : (quiet_r == 3'h7 ? quiet_r : quiet_r + 3'h1);
    end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////
  property p_rdata_idle; !i_rd |=> o_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_ctl1_read; i_rd && i_addr == 3'h7 |=> o_rdata == $past(c1_r); endproperty
  a_ctl1_read: assert property (p_ctl1_read) else $error("control one readback");
  property p_ctl0_resv; i_rd && i_addr == 3'h6 |=> !o_rdata[4]; endproperty
  a_ctl0_resv: assert property (p_ctl0_resv) else $error("control zero bit 4 set");
  property p_dis_pol; !en && quiet_r >= 3'h6 |-> o_timer_out_pin == pol; endproperty
  a_dis_pol: assert property (p_dis_pol) else $error("idle pin not at polarity");
  property p_dual_dis; !en && quiet_r >= 3'h6 && mode == 4'h8 |-> o_timer_out_comp == !pol; endproperty
  a_dual_dis: assert property (p_dual_dis) else $error("idle complement wrong");
  property p_pol_hold;
    ctl_wr && i_addr[0] && en && mode == 4'h1 && i_wdata[7] && i_wdata[2:0] == 3'h1 && i_wdata[6] != pol
      |=> $stable(o_timer_out_pin)[*4];
  endproperty
  a_pol_hold: assert property (p_pol_hold) else $error("pin moved on polarity write");
  property p_reload_toggle; o_timer_evt && en && mode == 4'h1 |-> ##2 $changed(o_timer_out_pin); endproperty
  a_reload_toggle: assert property (p_reload_toggle) else $error("no toggle after reload");
  property p_evt_single; o_timer_evt && en && mode == 4'h1 |=> !o_timer_evt; endproperty
  a_evt_single: assert property (p_evt_single) else $error("event longer than one cycle");
  c_reload: cover property (o_timer_evt && mode == 4'h1);
  c_dual_rise: cover property (en && mode == 4'h8 && $rose(o_timer_out_comp));
  c_capture: cover property (en && mode == 4'h4 && $changed(i_timer_in));
endmodule : tmp_timer_monitor
bind tmp_timer tmp_timer_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer_in(i_timer_in), .o_timer_out_pin(o_timer_out_pin),
  .o_timer_out_comp(o_timer_out_comp), .o_timer_evt(o_timer_evt));

// >>> sim/timer_mode_polarity_prescale_bench.sv
// self-checking bench for the timer control block
// assumes the byte register port and the pin model beside the design
`timescale 1ns/100ps
`include "tmp_defs.svh"
module timer_mode_polarity_prescale_bench;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, lvl = 1'b0, tin, out, comp, evt;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [15:0] a, b;
  int n_mismatch = 0, checks_done = 0, cyc = 0, c, c0, n, p, r;
  logic o;
  tmp_timer dut (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_timer_in(tin), .o_timer_out_pin(out), .o_timer_out_comp(comp), .o_timer_evt(evt));
  tmp_pin_model u_pin (.i_clk(clk), .i_lvl(lvl), .o_pin(tin));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  function automatic int period(int cnt, int pre); return cnt << pre; endfunction : period
  function automatic int dband(int d); return d == 0 ? 0 : 1 << d; endfunction : dband
  task automatic tick(int k); repeat (k) @(posedge clk); #1; endtask : tick
  task automatic wrb(input logic [2:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrb
  task automatic rd16(input logic [2:0] ad, output logic [15:0] v);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    addr <= ad + 3'h1;
    #1 v[15:8] = rdata;
    @(posedge clk);
    rd <= 1'b0;
    #1 v[7:0] = rdata;
  endtask : rd16
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // bounded wait for one event pulse, counting cycles
  task automatic wait_evt(output int k);
    k = 0;
    do begin tick(1); k++; end while (evt !== 1'b1 && k < 2000);
    if (k >= 2000) chk(16'h0, 16'h1);
  endtask : wait_evt
  // bounded wait for the output pin to reach a level, counting cycles
  task automatic wait_pin(input logic v, output int k);
    k = 0;
    while (out !== v && k < 2000)
    begin
      tick(1);
      k++;
    end
    if (k >= 2000) chk(16'h0, 16'h1);
  endtask : wait_pin
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // hang guard, well above the roughly eight thousand cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    r = $urandom(32'h5FEA);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // reset values of count, reload, pulse width
    rd16(3'h0, a); chk(a, `TMP_RST_CNT); rd16(3'h2, a); chk(a, `TMP_RST_RLD); rd16(3'h4, a); chk(a, 16'h0);
    $display("reset values done");
    // idle levels in all eleven modes and both polarities
    for (int m = 0; m < 11; m++)
      for (int q = 0; q < 2; q++)
      begin
        wrb(`TMP_ADDR_CTL0, {m[3], 7'h00}); wrb(`TMP_ADDR_CTL1, {1'b0, q[0], 3'h0, m[2:0]}); tick(8);
        chk(out, q[0]);
        if (m == 8) chk(comp, !q[0]);
      end
    $display("idle levels done");
    wrb(`TMP_ADDR_CTL0, 8'h00);
    // reload period at every prescale code
    for (p = 0; p < 8; p++)
    begin
      n = 4 + $urandom % 4;
      wrb(3'h0, 8'h00); wrb(3'h1, 8'h01); wrb(3'h2, 8'h00); wrb(3'h3, n[7:0]);
      wrb(`TMP_ADDR_CTL1, {2'b10, p[2:0], 3'h1});
      wait_evt(c); o = out; tick(3); chk(out, !o);
      wait_evt(c); chk(c + 3, period(n, p));
      tick(4); wrb(`TMP_ADDR_CTL1, 8'h01);
    end
    $display("prescale done");
    // restart after a random stop gives the same first event time
    for (int k = 0; k < 2; k++)
    begin
      wrb(`TMP_ADDR_CTL1, 8'h99); tick(1 + 3 * k + $urandom % 2); wrb(`TMP_ADDR_CTL1, 8'h19);
      wrb(3'h0, 8'h00); wrb(3'h1, 8'h01); wrb(`TMP_ADDR_CTL1, 8'h99); wait_evt(c);
      if (k == 0) c0 = c; else chk(c, c0);
      wrb(`TMP_ADDR_CTL1, 8'h19);
    end
    $display("prescaler clear done");
    // polarity write while running leaves the pin alone
    wrb(3'h2, 8'hFF); wrb(3'h3, 8'hFF); wrb(3'h1, 8'h01); wrb(`TMP_ADDR_CTL1, 8'h81); tick(5); o = out;
    wrb(`TMP_ADDR_CTL1, 8'hC1); tick(10); chk(out, o);
    wrb(`TMP_ADDR_CTL1, 8'h41); tick(8); chk(out, 1'b1);
    $display("polarity hold done");
    // capture on the selected edge only
    for (int q = 0; q < 2; q++)
    begin
      wrb(3'h4, 8'h00); wrb(3'h5, 8'h00); lvl <= !q[0]; tick(8);
      wrb(`TMP_ADDR_CTL1, {1'b1, q[0], 6'h04}); tick(4);
      lvl <= q[0]; tick(8); rd16(3'h4, a); chk(a, 16'h0);
      lvl <= !q[0]; tick(8); rd16(3'h4, a); rd16(3'h0, b);
      chk(a != 16'h0 && a < b, 1'b1);
      wrb(`TMP_ADDR_CTL1, 8'h04);
    end
    $display("capture done");
    // gated counting and the deasserting edge event
    p = $urandom % 2;
    lvl <= p[0]; tick(8); wrb(`TMP_ADDR_CTL1, {1'b1, p[0], 6'h06}); tick(4);
    rd16(3'h0, a); tick(20); rd16(3'h0, b); chk(b, a);
    lvl <= !p[0]; tick(20); lvl <= p[0]; wait_evt(c); chk(c < 10, 1'b1);
    rd16(3'h0, b); chk(b > a, 1'b1);
    wrb(`TMP_ADDR_CTL1, 8'h06);
    $display("gated done");
    // dead band delays the complement rise after reload
    wrb(3'h2, 8'h01); wrb(3'h3, 8'h90); wrb(3'h4, 8'h00); wrb(3'h5, 8'hC8);
    for (int d = 0; d < 8; d++)
    begin
      wrb(`TMP_ADDR_CTL0, {4'h8, d[2:0], 1'b0}); wrb(`TMP_ADDR_CTL1, 8'h80);
      c = 0;
      do
      begin
        o = out;
        tick(1);
        c++;
      end
      while (!(o === 1'b1 && out === 1'b0) && c < 2000);
      if (c >= 2000) chk(16'h0, 16'h1);
      n = 0;
      while (comp !== 1'b1 && n < 300) begin tick(1); n++; end
      chk(n, dband(d));
      wrb(`TMP_ADDR_CTL1, 8'h00);
    end
    $display("dead band done");
    // match and reload levels: single output at both polarities, dual output at polarity 1
    for (int q = 0; q < 3; q++)
    begin
      o = q[0] | q[1];
      wrb(`TMP_ADDR_CTL0, {q[1], 7'h00}); wrb(`TMP_ADDR_CTL1, {1'b0, o, 3'h0, q[1] ? 3'h0 : 3'h3});
      wrb(3'h0, 8'h00); wrb(3'h1, 8'h01); wrb(`TMP_ADDR_CTL1, {1'b1, o, 3'h0, q[1] ? 3'h0 : 3'h3});
      wait_pin(!o, c);
      if (q[1]) chk(comp, o);
      wait_pin(o, c);
      chk(c, 16'h0190 - 16'h00C8);
      if (q[1]) chk(comp, !o);
      wrb(`TMP_ADDR_CTL1, 8'h00);
    end
    $display("pulse-width levels done");
    // capture/compare idles until the first rising edge, then captures on later ones
    wrb(`TMP_ADDR_CTL0, 8'h00); lvl <= 1'b0; wrb(3'h0, 8'h00); wrb(3'h1, 8'h01);
    wrb(`TMP_ADDR_CTL1, 8'h87); tick(8);
    rd16(3'h0, a); chk(a, 16'h0001);
    lvl <= 1'b1; tick(8); rd16(3'h4, a); chk(a, 16'h00C8);
    lvl <= 1'b0; tick(4); lvl <= 1'b1; tick(8); rd16(3'h4, a); rd16(3'h0, b);
    chk(a > 16'h0001 && a < b && a != 16'h00C8, 1'b1);
    wrb(`TMP_ADDR_CTL1, 8'h07);
    $display("capture compare done");
    // counter mode steps on selected input edges and reloads on the first selected edge after reaching the reload value
    lvl <= 1'b0; wrb(3'h2, 8'h00); wrb(3'h3, 8'h03); wrb(3'h0, 8'h00); wrb(3'h1, 8'h01);
    wrb(`TMP_ADDR_CTL1, 8'h82);
    for (int k = 0; k < 3; k++)
    begin
      lvl <= 1'b1; tick(6); lvl <= 1'b0; tick(6); rd16(3'h0, a);
      chk(a, k < 2 ? 16'(k + 2) : 16'h0001);
    end
    wrb(`TMP_ADDR_CTL1, 8'h02);
    $display("counter done");
    end_sim;
  end
endmodule : timer_mode_polarity_prescale_bench
